//--- design/wdt_cfg_reg.sv
`timescale 1ns/1ns
`default_nettype none
// write-once option latch, cleared by every reset
module wdt_cfg_reg
	import wdt_pkg::*;
(
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_nrst,
	input  wire logic       i_clear,
	// write port
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wdata,
	// options
	output wdt_cfg_t        o_cfg,
	output logic            o_locked
);

	wdt_cfg_t cfg_q;
	logic     locked_q;

	// first write after a reset sticks, later ones are ignored
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg_q    <= wdt_cfg_t'(WDT_CFG_RESET);
			locked_q <= 1'b0;
		end else if (i_clear) begin
			cfg_q    <= wdt_cfg_t'(WDT_CFG_RESET);
			locked_q <= 1'b0;
		end else if (i_wr && !locked_q) begin
			cfg_q    <= wdt_cfg_t'(i_wdata);
			locked_q <= 1'b1;
		end
	end

	assign o_cfg    = cfg_q;
	assign o_locked = locked_q;

endmodule
`default_nettype wire

//--- design/wdt_delay.sv
`timescale 1ns/1ns
`default_nettype none
// one-shot down counter: busy for exactly load cycles after start
module wdt_delay
	import wdt_pkg::*;
#(
	parameter int W = WDT_DLY_W
) (
	// clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_nrst,
	// control
	input  wire logic         i_start,
	input  wire logic [W-1:0] i_load,
	// status
	output logic              o_busy,
	output logic              o_done
);

	localparam logic [W-1:0] ONE  = W'(1);
	localparam logic [W-1:0] NONE = W'(0);

	logic [W-1:0] cnt_q;

	// a new start restarts the count
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= NONE;
		end else if (i_start) begin
			cnt_q <= i_load;
		end else if (cnt_q != NONE) begin
			cnt_q <= cnt_q - ONE;
		end
	end

	assign o_busy = (cnt_q != NONE);
	assign o_done = (cnt_q == ONE);

endmodule
`default_nettype wire

//--- design/wdt_pkg.sv
// ***************************************************************
// watchdog shared constants and types
// ***************************************************************
package wdt_pkg;

	// counter chain, bus and delay widths
	localparam int WDT_PRE_W  = 12;
	localparam int WDT_CNT_W  = 6;
	localparam int WDT_DATA_W = 8;
	localparam int WDT_ADDR_W = 16;
	localparam int WDT_DLY_W  = 13;

	// register byte addresses
	localparam logic [15:0] WDT_SERVICE_ADDR = 16'hFFFF;
	localparam logic [15:0] WDT_CONFIG_ADDR  = 16'h001F;
	localparam logic [15:0] WDT_CAUSE_ADDR   = 16'h0001;

	// reset values
	localparam logic [7:0] WDT_CFG_RESET = 8'h00;
	localparam logic [7:0] WDT_ZERO_BYTE = 8'h00;

	// cause register field position
	localparam int WDT_CAUSE_BIT = 0;

	// prescaler bits kept by a service write (stages 12..5 cleared)
	localparam logic [11:0] WDT_PRE_SVC_KEEP = 12'h00F;

	// oscillator rate and delays, in oscillator cycles
	localparam int WDT_OSC_HZ          = 10_000_000;
	localparam int WDT_RST_PULSE_CYC   = 32;
	localparam int WDT_SHORT_REC_CYC   = 32;
	localparam int WDT_LONG_REC_CYC    = 4096;
	localparam int WDT_POR_CLR_CYC     = 4096;

	// option byte layout, msb first
	typedef struct packed {
		logic [2:0] spare;
		logic       rate_select;
		logic       voltage_mode_select;
		logic       short_stop_recovery;
		logic       stop_enable;
		logic       watchdog_disable;
	} wdt_cfg_t;

endpackage

//--- design/wdt_top.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - six-bit counter fed by twelve-bit prescaler
// - unserviced counter overflows into a reset
// - service write clears counter, prescaler upper stages
// - service read returns reset vector low byte
// - overflow drives reset low 32 cycles
// - monitor with test voltage holds watchdog off
// - blank-vector monitor disables until power-on
// - break with reset-pin test voltage disables
// - stop clears prescaler and halts counting
// - prescaler cleared 4096 cycles after power-up
// - internal reset clears prescaler and counter
// - reset vector fetch clears the prescaler
// - never raises a cpu interrupt
// - keeps counting during wait mode
// - stop disabled means illegal opcode reset
// - disable option turns the watchdog off
// - short recovery 32 cycles, else 4096
// - reset-pin stop exit always recovers long
// - voltage select picks 5v or 3v mode
// - rate select picks short or long timeout
// - options cleared by reset, written once
module wdt_top
	import wdt_pkg::*;
#(
	parameter int PRE_W = WDT_PRE_W,
	parameter int CNT_W = WDT_CNT_W
) (
	// clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_nrst,
	// register port
	input  wire logic [WDT_ADDR_W-1:0] i_addr,
	input  wire logic [WDT_DATA_W-1:0] i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic      [WDT_DATA_W-1:0] o_rdata,
	// vector path
	input  wire logic [WDT_DATA_W-1:0] i_reset_vector_lo,
	input  wire logic                  i_vector_fetch,
	// system state
	input  wire logic                  i_int_reset,
	input  wire logic                  i_stop_exec,
	input  wire logic                  i_stop_mode,
	input  wire logic                  i_stop_wake,
	input  wire logic                  i_wake_by_pin,
	// test and debug conditions
	input  wire logic                  i_monitor_vtst_entry,
	input  wire logic                  i_monitor_blank_entry,
	input  wire logic                  i_irq_vtst,
	input  wire logic                  i_rst_vtst,
	input  wire logic                  i_break,
	// reset pin, open drain
	output logic                       o_rst_pin_o,
	output logic                       o_rst_pin_oe,
	// system outputs
	output logic                       o_illegal_stop,
	output logic                       o_stop_exit,
	output logic                       o_lvd_5v_mode
);

	// ***********************************************************
	// local constants
	// ***********************************************************
	localparam logic [PRE_W-1:0] PRE_ONE  = PRE_W'(1);
	localparam logic [PRE_W-1:0] PRE_ZERO = PRE_W'(0);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
	localparam logic [PRE_W-1:0] PRE_KEEP = PRE_W'(WDT_PRE_SVC_KEEP);
	localparam logic [WDT_DLY_W-1:0] RST_PULSE =
		WDT_DLY_W'(WDT_RST_PULSE_CYC);
	localparam logic [WDT_DLY_W-1:0] SHORT_REC =
		WDT_DLY_W'(WDT_SHORT_REC_CYC);
	localparam logic [WDT_DLY_W-1:0] LONG_REC =
		WDT_DLY_W'(WDT_LONG_REC_CYC);
	localparam logic [WDT_DLY_W-1:0] POR_CLR =
		WDT_DLY_W'(WDT_POR_CLR_CYC);

	// ***********************************************************
	// declarations
	// ***********************************************************
	wdt_cfg_t             cfg;
	logic [PRE_W-1:0]     pre_q;
	logic [CNT_W-1:0]     cnt_q;
	logic [7:0]           rdata_q;
	logic [WDT_DLY_W-1:0] rec_load;
	logic                 cause_q, mon_hold_q, mon_blank_q, por_arm_q;
	logic                 illegal_q, svc_wr, svc_rd, cfg_wr, cause_rd;
	logic                 wd_active, tick, pre_term, ovf, stop_ok;
	logic                 por_start, por_done, pre_clr, any_reset;
	logic                 rst_busy;

	// ***********************************************************
	// address decode
	// ***********************************************************
	// writes of any data count as a service
	assign svc_wr   = i_wr && (i_addr == WDT_SERVICE_ADDR);
	assign svc_rd   = i_rd && (i_addr == WDT_SERVICE_ADDR);
	assign cfg_wr   = i_wr && (i_addr == WDT_CONFIG_ADDR);
	assign cause_rd = i_rd && (i_addr == WDT_CAUSE_ADDR);

	// ***********************************************************
	// option byte
	// ***********************************************************
	// own overflow is an internal reset too, so it clears options
	assign any_reset = i_int_reset || ovf;

	wdt_cfg_reg u_cfg (
		.i_clock  (i_clock),
		.i_nrst   (i_nrst),
		.i_clear  (any_reset),
		.i_wr     (cfg_wr),
		.i_wdata  (i_wdata),
		.o_cfg    (cfg),
		.o_locked ()
	);

	// low voltage detector mode straight from the option
	assign o_lvd_5v_mode = cfg.voltage_mode_select;

	// ***********************************************************
	// enable conditions
	// ***********************************************************
	// monitor hold lasts while either pin keeps the test voltage
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			mon_hold_q <= 1'b0;
		end else if (i_monitor_vtst_entry && i_irq_vtst) begin
			mon_hold_q <= 1'b1;
		end else if (!i_irq_vtst && !i_rst_vtst) begin
			mon_hold_q <= 1'b0;
		end
	end

	// blank-vector monitor entry: only power-on clears it
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			mon_blank_q <= 1'b0;
		end else if (i_monitor_blank_entry && !i_irq_vtst) begin
			mon_blank_q <= 1'b1;
		end
	end

	// wait mode is deliberately absent here: counting goes on
	assign wd_active = !cfg.watchdog_disable && !mon_hold_q
		&& !mon_blank_q && !(i_break && i_rst_vtst);

	// stop gates the oscillator off; wait does not
	assign tick = wd_active && !i_stop_mode;

	// ***********************************************************
	// power-on prescaler clear
	// ***********************************************************
	// arm one start pulse in the first cycle after release
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			por_arm_q <= 1'b0;
		end else begin
			por_arm_q <= 1'b1;
		end
	end

	assign por_start = !por_arm_q;

	wdt_delay #(
		.W (WDT_DLY_W)
	) u_por (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_start (por_start),
		.i_load  (POR_CLR),
		.o_busy  (),
		.o_done  (por_done)
	);

	// ***********************************************************
	// counter chain
	// ***********************************************************
	assign pre_term = &pre_q;

	// carry out of the chosen counter bit is the overflow event
	assign ovf = tick && pre_term
		&& (cfg.rate_select ? cnt_q[0] : &cnt_q);

	// only an allowed stop clears; a refused one resets instead
	assign stop_ok = i_stop_exec && cfg.stop_enable;

	// prescaler-only clear sources
	assign pre_clr = stop_ok || i_vector_fetch
		|| por_done;

	// prescaler: resets first, then clears, then the count
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			pre_q <= PRE_ZERO;
		end else if (any_reset) begin
			pre_q <= PRE_ZERO;
		end else if (pre_clr) begin
			pre_q <= PRE_ZERO;
		end else if (svc_wr) begin
			pre_q <= pre_q & PRE_KEEP;
		end else if (tick) begin
			pre_q <= pre_q + PRE_ONE;
		end
	end

	// counter: one step per prescaler terminal tick
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= CNT_ZERO;
		end else if (any_reset || svc_wr) begin
			cnt_q <= CNT_ZERO;
		end else if (tick && pre_term) begin
			cnt_q <= cnt_q + CNT_ONE;
		end
	end

	// ***********************************************************
	// reset output
	// ***********************************************************
	// expiry only ever pulls the reset pin; no interrupt path
	wdt_delay #(
		.W (WDT_DLY_W)
	) u_rst (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_start (ovf),
		.i_load  (RST_PULSE),
		.o_busy  (rst_busy),
		.o_done  ()
	);

	// open drain: level is always low, enable does the work
	assign o_rst_pin_o  = 1'b0;
	assign o_rst_pin_oe = rst_busy;

	// cause flag: a new overflow wins over a read-clear
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			cause_q <= 1'b0;
		end else if (ovf) begin
			cause_q <= 1'b1;
		end else if (cause_rd) begin
			cause_q <= 1'b0;
		end
	end

	// ***********************************************************
	// stop handling
	// ***********************************************************
	// refused stop is reported as a one-cycle illegal opcode
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			illegal_q <= 1'b0;
		end else begin
			illegal_q <= i_stop_exec && !cfg.stop_enable;
		end
	end

	assign o_illegal_stop = illegal_q;

	// pin wake ignores the short option; oscillator needs time
	assign rec_load = (cfg.short_stop_recovery && !i_wake_by_pin)
		? SHORT_REC : LONG_REC;

	wdt_delay #(
		.W (WDT_DLY_W)
	) u_rec (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_start (i_stop_wake),
		.i_load  (rec_load),
		.o_busy  (),
		.o_done  (o_stop_exit)
	);

	// ***********************************************************
	// read data
	// ***********************************************************
	// service location shows the vector, never watchdog state
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_q <= WDT_ZERO_BYTE;
		end else if (svc_rd) begin
			rdata_q <= i_reset_vector_lo;
		end else if (i_rd && (i_addr == WDT_CONFIG_ADDR)) begin
			rdata_q <= cfg;
		end else if (cause_rd) begin
			rdata_q <= WDT_ZERO_BYTE;
			rdata_q[WDT_CAUSE_BIT] <= cause_q;
		end else begin
			rdata_q <= WDT_ZERO_BYTE;
		end
	end

	assign o_rdata = rdata_q;

	// ***********************************************************
	// assertions
	// ***********************************************************
	property p_rst_pulse;
		@(posedge i_clock) disable iff (!i_nrst)
		ovf |=> o_rst_pin_oe ##31 o_rst_pin_oe ##1 !o_rst_pin_oe;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("reset pulse not 32 cycles");
	property p_cause_set;
		@(posedge i_clock) disable iff (!i_nrst)
		ovf |=> cause_q;
	endproperty
	a_cause_set: assert property (p_cause_set)
		else $error("cause flag missed overflow");
	property p_svc_clear;
		@(posedge i_clock) disable iff (!i_nrst)
		svc_wr |=> (cnt_q == CNT_ZERO) && ((pre_q & ~PRE_KEEP) == PRE_ZERO);
	endproperty
	a_svc_clear: assert property (p_svc_clear)
		else $error("service write did not clear");
	property p_read_vec;
		@(posedge i_clock) disable iff (!i_nrst)
		svc_rd |=> o_rdata == $past(i_reset_vector_lo);
	endproperty
	a_read_vec: assert property (p_read_vec)
		else $error("service read not vector byte");
	property p_int_rst;
		@(posedge i_clock) disable iff (!i_nrst)
		i_int_reset |=> (pre_q == PRE_ZERO) && (cnt_q == CNT_ZERO);
	endproperty
	a_int_rst: assert property (p_int_rst)
		else $error("internal reset did not clear chain");
	property p_stop_gate;
		@(posedge i_clock) disable iff (!i_nrst)
		i_stop_mode && !pre_clr && !svc_wr && !i_int_reset
			|=> $stable(pre_q);
	endproperty
	a_stop_gate: assert property (p_stop_gate)
		else $error("prescaler moved in stop");
	property p_illegal;
		@(posedge i_clock) disable iff (!i_nrst)
		i_stop_exec && !cfg.stop_enable |=> o_illegal_stop;
	endproperty
	a_illegal: assert property (p_illegal)
		else $error("refused stop not reported");
	property p_disable;
		@(posedge i_clock) disable iff (!i_nrst)
		cfg.watchdog_disable || mon_blank_q |-> !ovf && !tick;
	endproperty
	a_disable: assert property (p_disable)
		else $error("disabled watchdog still counting");
	property p_short_rec;
		@(posedge i_clock) disable iff (!i_nrst)
		i_stop_wake && cfg.short_stop_recovery && !i_wake_by_pin
			|-> ##32 o_stop_exit;
	endproperty
	a_short_rec: assert property (p_short_rec)
		else $error("short recovery not 32 cycles");
	// a later wake only pushes the exit further out, never onto cycle 32
	property p_pin_rec;
		@(posedge i_clock) disable iff (!i_nrst)
		i_stop_wake && i_wake_by_pin |-> ##32 !o_stop_exit;
	endproperty
	a_pin_rec: assert property (p_pin_rec)
		else $error("pin wake used short recovery");

endmodule
`default_nettype wire

//--- verif/watchdog_timer_with_options_tb.sv
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer_with_options_tb
	import wdt_pkg::*;
;
	// ***************************************************************
	// signals
	// ***************************************************************
	localparam int TEST_NS = 100_000 * 100;
	logic clk, nrst, wr, rd, vfetch, int_rst, stop_exec, stop_mode;
	logic stop_wake, wake_pin, mon_vtst, mon_blank, irq_vtst, rst_vtst;
	logic brk, rst_o, rst_oe, illegal, stop_exit, lvd5;
	logic [15:0] addr;
	logic [7:0]  wdata, rdata, vec, d;
	int          bad_count, samples_checked, n;

	wdt_cpu_model wdt_cpu_model_inst (.i_clock(clk), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));

	wdt_top wdt_top_inst (.i_clock(clk), .i_nrst(nrst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_reset_vector_lo(vec), .i_vector_fetch(vfetch),
		.i_int_reset(int_rst), .i_stop_exec(stop_exec),
		.i_stop_mode(stop_mode), .i_stop_wake(stop_wake),
		.i_wake_by_pin(wake_pin), .i_monitor_vtst_entry(mon_vtst),
		.i_monitor_blank_entry(mon_blank), .i_irq_vtst(irq_vtst),
		.i_rst_vtst(rst_vtst), .i_break(brk), .o_rst_pin_o(rst_o),
		.o_rst_pin_oe(rst_oe), .o_illegal_stop(illegal),
		.o_stop_exit(stop_exit), .o_lvd_5v_mode(lvd5));

	// 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ***************************************************************
	// helpers
	// ***************************************************************
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask

	task automatic rng(input string nm, input int lo, input int hi);
		samples_checked++;
		if (n < lo || n > hi) begin
			$display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, n);
			bad_count++;
		end
	endtask

	// counts cycles with the reset pin not released
	task automatic quiet(input int cyc);
		n = 0;
		repeat (cyc) begin
			@(posedge clk);
			#1;
			if (rst_oe !== 1'b0) n++;
		end
	endtask

	// edges until reset pin pull starts, bounded
	task automatic to_oe(input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (rst_oe !== 1'b1 && n < lim);
	endtask

	// length of the reset pin pull
	task automatic oe_width();
		n = 0;
		while (rst_oe === 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	// edges from a wake request to recovery done
	task automatic wake(input logic by_pin);
		@(posedge clk);
		stop_wake <= 1'b1;
		wake_pin  <= by_pin;
		@(posedge clk);
		stop_wake <= 1'b0;
		n = 1;
		#1;
		while (stop_exit !== 1'b1 && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	// internal reset, then options and a service
	task automatic fresh(input logic [7:0] cfg);
		@(posedge clk);
		int_rst <= 1'b1;
		@(posedge clk);
		int_rst <= 1'b0;
		wdt_cpu_model_inst.wr(WDT_CONFIG_ADDR, cfg);
		wdt_cpu_model_inst.service();
	endtask

	task automatic stop_pulse();
		@(posedge clk);
		stop_exec <= 1'b1;
		@(posedge clk);
		stop_exec <= 1'b0;
		#1;
	endtask

	task automatic conclude();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// hang guard at 100,000 cycles, only a little beyond the planned run
	initial begin
		#(TEST_NS);
		bad_count++;
		conclude();
	end

	// ***************************************************************
	// tests
	// ***************************************************************
	initial begin
		{nrst, vfetch, int_rst, stop_exec, stop_mode, stop_wake} = '0;
		{wake_pin, mon_vtst, mon_blank, irq_vtst, rst_vtst, brk} = '0;
		vec = 8'h5A;
		bad_count = 0;
		samples_checked = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		// reset state and the overlapped vector byte
		wdt_cpu_model_inst.rd(WDT_CONFIG_ADDR, d);
		chk("config", 16'h0000, {8'h00, d});
		wdt_cpu_model_inst.rd(WDT_SERVICE_ADDR, d);
		chk("vector", 16'h005A, {8'h00, d});
		wdt_cpu_model_inst.rd(16'h0002, d);
		chk("unmapped", 16'h0000, {8'h00, d});
		chk("lvd", 16'h0000, {15'h0000, lvd5});
		// second option write must be ignored
		wdt_cpu_model_inst.wr(WDT_CONFIG_ADDR, 8'h18);
		wdt_cpu_model_inst.wr(WDT_CONFIG_ADDR, 8'h00);
		wdt_cpu_model_inst.rd(WDT_CONFIG_ADDR, d);
		chk("config once", 16'h0018, {8'h00, d});
		chk("lvd", 16'h0001, {15'h0000, lvd5});
		@(posedge clk);
		vfetch <= 1'b1;
		@(posedge clk);
		vfetch <= 1'b0;
		// past the power-on prescaler clear before timing a period
		repeat (4200) @(posedge clk);
		wdt_cpu_model_inst.service();
		to_oe(9000);
		rng("short timeout", 8175, 8194);
		oe_width();
		chk("pull width", 16'd32, 16'(n));
		chk("pin level", 16'h0000, {15'h0000, rst_o});
		wdt_cpu_model_inst.rd(WDT_CAUSE_ADDR, d);
		chk("cause", 16'h0001, {15'h0000, d[WDT_CAUSE_BIT]});
		wdt_cpu_model_inst.rd(WDT_CONFIG_ADDR, d);
		chk("config after", 16'h0000, {8'h00, d});
		// disabled watchdog never pulls
		fresh(8'h11);
		quiet(9000);
		chk("disabled", 16'h0000, 16'(n));
		// stop allowed, short recovery; crystal users would leave it off
		fresh(8'h16);
		stop_pulse();
		chk("stop legal", 16'h0000, {15'h0000, illegal});
		@(posedge clk);
		stop_mode <= 1'b1;
		quiet(9000);
		chk("stop frozen", 16'h0000, 16'(n));
		wake(1'b0);
		chk("short wake", 16'd32, 16'(n));
		wake(1'b1);
		chk("pin wake", 16'd4096, 16'(n));
		@(posedge clk);
		stop_mode <= 1'b0;
		// stop refused when not enabled
		fresh(8'h10);
		stop_pulse();
		chk("illegal", 16'h0001, {15'h0000, illegal});
		@(posedge clk);
		#1;
		chk("illegal end", 16'h0000, {15'h0000, illegal});
		// vector fetch restarts the prescaler but keeps the counter
		repeat (2000) @(posedge clk);
		vfetch <= 1'b1;
		@(posedge clk);
		vfetch <= 1'b0;
		to_oe(8300);
		chk("vector fetch", 16'd8192, 16'(n));
		oe_width();
		// monitor entry with test voltage held on the interrupt pin
		fresh(8'h10);
		irq_vtst <= 1'b1;
		mon_vtst <= 1'b1;
		@(posedge clk);
		mon_vtst <= 1'b0;
		quiet(9000);
		chk("monitor hold", 16'h0000, 16'(n));
		@(posedge clk);
		irq_vtst <= 1'b0;
		to_oe(8300);
		rng("monitor released", 1, 8299);
		oe_width();
		// break with test voltage on the reset pin
		fresh(8'h10);
		brk      <= 1'b1;
		rst_vtst <= 1'b1;
		quiet(9000);
		chk("break hold", 16'h0000, 16'(n));
		@(posedge clk);
		brk      <= 1'b0;
		rst_vtst <= 1'b0;
		// blank-vector monitor survives an internal reset
		@(posedge clk);
		mon_blank <= 1'b1;
		@(posedge clk);
		mon_blank <= 1'b0;
		fresh(8'h10);
		quiet(9000);
		chk("blank monitor", 16'h0000, 16'(n));
		// power-on lifts the blank monitor and redoes the prescaler clear
		@(posedge clk);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		wdt_cpu_model_inst.wr(WDT_CONFIG_ADDR, 8'h10);
		repeat (16) @(posedge clk);
		wdt_cpu_model_inst.service();
		to_oe(12400);
		chk("power-on clear", 16'd12269, 16'(n));
		conclude();
	end
endmodule
`default_nettype wire

//--- verif/wdt_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ***************************************************************
// cpu bus master model
// ***************************************************************
module wdt_cpu_model
	import wdt_pkg::*;
(
	// clock
	input  wire logic                  i_clock,
	// bus toward the watchdog
	output logic      [WDT_ADDR_W-1:0] o_addr,
	output logic      [WDT_DATA_W-1:0] o_wdata,
	output logic                       o_wr,
	output logic                       o_rd,
	input  wire logic [WDT_DATA_W-1:0] i_rdata
);
	// idle bus at time zero
	initial begin
		o_addr  = 16'h0000;
		o_wdata = 8'h00;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
	end

	// one write cycle; idle lines flip so stale values never look valid
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clock);
		o_wr    <= 1'b1;
		o_addr  <= a;
		o_wdata <= d;
		@(posedge i_clock);
		o_wr    <= 1'b0;
		o_addr  <= ~a;
		o_wdata <= ~d;
	endtask

	// one read cycle; data taken in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge i_clock);
		o_rd   <= 1'b1;
		o_addr <= a;
		@(posedge i_clock);
		o_rd   <= 1'b0;
		o_addr <= ~a;
		#1;
		d = i_rdata;
	endtask

	// serviced before each timed run so the first period is whole
	task automatic service();
		wr(WDT_SERVICE_ADDR, 8'hA5);
	endtask
endmodule
`default_nettype wire
